// [hdl/tsf_consts.svh]
// Constants for the timer channel 3/4/5 status flag bank
// Notes on behaviour
// R01: Ch3 register: wrap bit 4, D..A bits 3..0
// R02: Ch4/5 register: wrap4 7, D..A 6..3, ch5 2..0
// R03: Ch3 counter FFFF to 0000 sets ch3 wrap
// R04: Ch4 counter FFFF to 0000 sets ch4 wrap
// R05: Ch3 capture into capture-mode register sets flag
// R06: Ch3 compare match in compare mode sets flag
// R07: Ch4 capture into capture-mode register sets flag
// R08: Ch4 compare match in compare mode sets flag
// R09: Clear only by read-as-one then write zero
// R10: Writing one to a flag does nothing
// R11: Ch3 register upper bits read zero
// R12: Software writes zeros to ch3 upper bits
// R13: All flags read zero after reset
// R14: Ch5 counter FFFF to 0000 sets ch5 wrap
// R15: Ch5 capture or compare match sets flag
// R16: Set in clearing cycle keeps flag set
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH

`define TSF_ADDR_W        5
`define TSF_OFF_CH3       5'h00
`define TSF_OFF_CH45      5'h04
`define TSF_OFF_MODE      5'h08
`define TSF_OFF_IRQ_STAT  5'h0C
`define TSF_OFF_IRQ_MASK  5'h10

`define TSF_CNT_W         16
`define TSF_CNT_MAX       16'hFFFF
`define TSF_CNT_ZERO      16'h0000
`define TSF_N_GR          10
`define TSF_CH4_FIRST     4
`define TSF_CH5_FIRST     8

`define TSF_CH3_W         5
`define TSF_CH45_W        8
`define TSF_IRQ_W         13
`define TSF_CH3_WRAP_BIT  4
`define TSF_CH4_WRAP_BIT  7
`define TSF_CH5_WRAP_BIT  2

`define TSF_FLAG_RST      1'b0
`define TSF_MODE_RST      10'h000
`define TSF_IRQ_RST       13'h0000
`define TSF_DATA_RST      32'h0000_0000
`define TSF_RESP_OKAY     2'h0
`define TSF_RESP_SLVERR   2'h2

`endif

// [hdl/tsf_pkg.sv]
// Types for the timer channel 3/4/5 status flag bank
package tsf_pkg;
   typedef enum logic [1:0] {
      tsf_w_collect = 2'b01,
      tsf_w_resp    = 2'b10
   } tsf_wr_state_type;

   typedef enum logic [1:0] {
      tsf_r_idle = 2'b01,
      tsf_r_data = 2'b10
   } tsf_rd_state_type;
endpackage

// [hdl/tsf_flag_bank.sv]
// Sticky flag bank, armed by a read, cleared by a zero write
`timescale 1ns/1ps
`include "tsf_consts.svh"
module tsf_flag_bank #(
   parameter int WIDTH = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] set_evt,
   input  wire logic             rd_take,
   input  wire logic             wr_take,
   input  wire logic [WIDTH-1:0] wr_bits,
   output logic      [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] armed;
   logic [WIDTH-1:0] clr_ok;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign clr_ok[i] = wr_take && !wr_bits[i] && armed[i];

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               flags[i] <= `TSF_FLAG_RST; // R13
            end else if (set_evt[i]) begin
               flags[i] <= 1'b1; // R16
            end else if (clr_ok[i]) begin
               flags[i] <= 1'b0; // R09 R10
            end
         end

         // Arm holds the value seen by the last read, cleared by a write that has no read in the same cycle
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               armed[i] <= 1'b0;
            end else if (rd_take) begin
               armed[i] <= flags[i]; // R09
            end else if (wr_take) begin
               armed[i] <= 1'b0;
            end
         end

         sequence s_read_one;
            rd_take && flags[i];
         endsequence

         sequence s_zero_write;
            wr_take && !wr_bits[i] && !rd_take && !set_evt[i];
         endsequence

         property p_read_then_clear;
            @(posedge aclk) disable iff (!aresetn)
            s_read_one ##1 s_zero_write |=> !flags[i];
         endproperty
         a_read_then_clear: assert property (p_read_then_clear) // R09
            else $error("flag not cleared after read then zero write");

         property p_clear_cause;
            @(posedge aclk) disable iff (!aresetn)
            $fell(flags[i]) |-> $past(clr_ok[i]);
         endproperty
         a_clear_cause: assert property (p_clear_cause) // R09
            else $error("flag cleared without armed zero write");

         property p_rise_cause;
            @(posedge aclk) disable iff (!aresetn)
            $rose(flags[i]) |-> $past(set_evt[i]);
         endproperty
         a_rise_cause: assert property (p_rise_cause) // R10
            else $error("flag set without an event");

         property p_set_wins;
            @(posedge aclk) disable iff (!aresetn)
            set_evt[i] |=> flags[i];
         endproperty
         a_set_wins: assert property (p_set_wins) // R16
            else $error("event lost");
      end
   endgenerate

   property p_reset_zero;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (flags == '0);
   endproperty
   a_reset_zero: assert property (p_reset_zero) // R13
      else $error("flags not zero after reset");
endmodule

// [hdl/tsf_status_top.sv]
// Timer channel 3/4/5 status flags behind an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tsf_consts.svh"
module tsf_status_top (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [`TSF_ADDR_W-1:0]  awaddr,
   input  wire logic [2:0]              awprot,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [`TSF_ADDR_W-1:0]  araddr,
   input  wire logic [2:0]              arprot,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   input  wire logic [`TSF_CNT_W-1:0]   ch3_counter,
   input  wire logic [`TSF_CNT_W-1:0]   ch4_counter,
   input  wire logic [`TSF_CNT_W-1:0]   ch5_counter,
   input  wire logic [`TSF_CNT_W-1:0]   ch3_general_reg_a,
   input  wire logic [`TSF_CNT_W-1:0]   ch3_general_reg_b,
   input  wire logic [`TSF_CNT_W-1:0]   ch3_general_reg_c,
   input  wire logic [`TSF_CNT_W-1:0]   ch3_general_reg_d,
   input  wire logic [`TSF_CNT_W-1:0]   ch4_general_reg_a,
   input  wire logic [`TSF_CNT_W-1:0]   ch4_general_reg_b,
   input  wire logic [`TSF_CNT_W-1:0]   ch4_general_reg_c,
   input  wire logic [`TSF_CNT_W-1:0]   ch4_general_reg_d,
   input  wire logic [`TSF_CNT_W-1:0]   ch5_general_reg_a,
   input  wire logic [`TSF_CNT_W-1:0]   ch5_general_reg_b,
   input  wire logic [`TSF_N_GR-1:0]    capture_strobe,
   output logic [`TSF_CH3_W-1:0]        timer_ch3_status,
   output logic [`TSF_CH45_W-1:0]       timer_ch4_ch5_status,
   output logic                         irq
);
   tsf_pkg::tsf_wr_state_type  wr_state;
   tsf_pkg::tsf_rd_state_type  rd_state;
   logic                       aw_full;
   logic                       w_full;
   logic [`TSF_ADDR_W-1:0]     wr_addr;
   logic [31:0]                wr_data;
   logic [3:0]                 wr_strb;
   logic [`TSF_ADDR_W-1:0]     wr_word;
   logic [`TSF_ADDR_W-1:0]     rd_word;
   logic [31:0]                wr_mask;
   logic                       wr_go;
   logic                       wr_ch3;
   logic                       wr_ch45;
   logic                       wr_mode;
   logic                       wr_istat;
   logic                       wr_imask;
   logic                       wr_hit;
   logic                       rd_go;
   logic                       rd_is_ch3;
   logic [31:0]                next_rdata;
   logic [1:0]                 next_rresp;
   logic [`TSF_N_GR-1:0]       mode;
   logic [`TSF_IRQ_W-1:0]      irq_status;
   logic [`TSF_IRQ_W-1:0]      irq_mask;
   logic [`TSF_IRQ_W-1:0]      irq_events;
   logic [`TSF_CNT_W-1:0]      ch3_prev;
   logic [`TSF_CNT_W-1:0]      ch4_prev;
   logic [`TSF_CNT_W-1:0]      ch5_prev;
   logic                       ch3_wrap_flag_set;
   logic                       ch4_wrap_flag_set;
   logic                       ch5_wrap_flag_set;
   logic [`TSF_CNT_W-1:0]      gr_val [`TSF_N_GR];
   logic [`TSF_N_GR-1:0]       eq_now;
   logic [`TSF_N_GR-1:0]       eq_prev;
   logic [`TSF_N_GR-1:0]       gr_evt;
   logic [`TSF_N_GR-1:0]       gr_flag;
   logic [`TSF_CH3_W-1:0]      ch3_set;
   logic [`TSF_CH45_W-1:0]     ch45_set;
   // Write channel: address and data may arrive in either order
   assign wr_go    = (wr_state == tsf_pkg::tsf_w_collect) && aw_full && w_full;
   assign wr_word  = {wr_addr[`TSF_ADDR_W-1:2], 2'b00};
   assign wr_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_ch3   = wr_go && (wr_word == `TSF_OFF_CH3);
   assign wr_ch45  = wr_go && (wr_word == `TSF_OFF_CH45);
   assign wr_mode  = wr_go && (wr_word == `TSF_OFF_MODE);
   assign wr_istat = wr_go && (wr_word == `TSF_OFF_IRQ_STAT);
   assign wr_imask = wr_go && (wr_word == `TSF_OFF_IRQ_MASK);
   assign wr_hit   = wr_ch3 | wr_ch45 | wr_mode | wr_istat | wr_imask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         awready <= 1'b1;
         wr_addr <= '0;
      end else if (awvalid && awready) begin
         aw_full <= 1'b1;
         awready <= 1'b0;
         wr_addr <= awaddr;
      end else if (bvalid && bready) begin
         aw_full <= 1'b0;
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full  <= 1'b0;
         wready  <= 1'b1;
         wr_data <= `TSF_DATA_RST;
         wr_strb <= 4'h0;
      end else if (wvalid && wready) begin
         w_full  <= 1'b1;
         wready  <= 1'b0;
         wr_data <= wdata;
         wr_strb <= wstrb;
      end else if (bvalid && bready) begin
         w_full  <= 1'b0;
         wready  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= tsf_pkg::tsf_w_collect;
         bvalid   <= 1'b0;
         bresp    <= `TSF_RESP_OKAY;
      end else begin
         unique case (wr_state)
            tsf_pkg::tsf_w_collect: begin
               if (wr_go) begin
                  bvalid   <= 1'b1;
                  bresp    <= wr_hit ? `TSF_RESP_OKAY : `TSF_RESP_SLVERR;
                  wr_state <= tsf_pkg::tsf_w_resp;
               end
            end
            tsf_pkg::tsf_w_resp: begin
               if (bready) begin
                  bvalid   <= 1'b0;
                  wr_state <= tsf_pkg::tsf_w_collect;
               end
            end
         endcase
      end
   end

   // Read channel: data registered one cycle after the address
   assign rd_go   = (rd_state == tsf_pkg::tsf_r_idle) && arvalid;
   assign rd_word = {araddr[`TSF_ADDR_W-1:2], 2'b00};

   always_comb begin
      next_rdata = `TSF_DATA_RST;
      next_rresp = `TSF_RESP_OKAY;
      case (rd_word)
         `TSF_OFF_CH3:      next_rdata = {27'h0000000, timer_ch3_status}; // R11
         `TSF_OFF_CH45:     next_rdata = {24'h000000, timer_ch4_ch5_status};
         `TSF_OFF_MODE:     next_rdata = {22'h000000, mode};
         `TSF_OFF_IRQ_STAT: next_rdata = {19'h00000, irq_status};
         `TSF_OFF_IRQ_MASK: next_rdata = {19'h00000, irq_mask};
         default:           next_rresp = `TSF_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state  <= tsf_pkg::tsf_r_idle;
         arready   <= 1'b1;
         rvalid    <= 1'b0;
         rdata     <= `TSF_DATA_RST;
         rresp     <= `TSF_RESP_OKAY;
         rd_is_ch3 <= 1'b0;
      end else begin
         unique case (rd_state)
            tsf_pkg::tsf_r_idle: begin
               if (arvalid) begin
                  arready   <= 1'b0;
                  rvalid    <= 1'b1;
                  rdata     <= next_rdata;
                  rresp     <= next_rresp;
                  rd_is_ch3 <= (rd_word == `TSF_OFF_CH3);
                  rd_state  <= tsf_pkg::tsf_r_data;
               end
            end
            tsf_pkg::tsf_r_data: begin
               if (rready) begin
                  rvalid   <= 1'b0;
                  arready  <= 1'b1;
                  rd_state <= tsf_pkg::tsf_r_idle;
               end
            end
         endcase
      end
   end

   // Capture/compare select, 1 = capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode <= `TSF_MODE_RST;
      end else if (wr_mode) begin
         mode <= (mode & ~wr_mask[`TSF_N_GR-1:0])
                 | (wr_data[`TSF_N_GR-1:0] & wr_mask[`TSF_N_GR-1:0]);
      end
   end

   // Counter history for wrap detection
   always_ff @(posedge aclk) begin
      ch3_prev <= ch3_counter;
      ch4_prev <= ch4_counter;
      ch5_prev <= ch5_counter;
   end
   assign ch3_wrap_flag_set = (ch3_prev == `TSF_CNT_MAX) && (ch3_counter == `TSF_CNT_ZERO); // R03
   assign ch4_wrap_flag_set = (ch4_prev == `TSF_CNT_MAX) && (ch4_counter == `TSF_CNT_ZERO); // R04
   assign ch5_wrap_flag_set = (ch5_prev == `TSF_CNT_MAX) && (ch5_counter == `TSF_CNT_ZERO); // R14
   assign gr_val[0] = ch3_general_reg_a;
   assign gr_val[1] = ch3_general_reg_b;
   assign gr_val[2] = ch3_general_reg_c;
   assign gr_val[3] = ch3_general_reg_d;
   assign gr_val[4] = ch4_general_reg_a;
   assign gr_val[5] = ch4_general_reg_b;
   assign gr_val[6] = ch4_general_reg_c;
   assign gr_val[7] = ch4_general_reg_d;
   assign gr_val[8] = ch5_general_reg_a;
   assign gr_val[9] = ch5_general_reg_b;
   genvar g;
   generate
      for (g = 0; g < `TSF_N_GR; g++) begin : g_gr
         logic [`TSF_CNT_W-1:0] cnt_sel;
         if (g < `TSF_CH4_FIRST) begin : g_c3
            assign cnt_sel = ch3_counter;
         end else if (g < `TSF_CH5_FIRST) begin : g_c4
            assign cnt_sel = ch4_counter;
         end else begin : g_c5
            assign cnt_sel = ch5_counter;
         end
         assign eq_now[g] = (cnt_sel == gr_val[g]);
         // Match is flagged once as the counter reaches the value
         assign gr_evt[g] = mode[g] ? capture_strobe[g]
                                    : (eq_now[g] && !eq_prev[g]); // R05 R06 R07 R08 R15

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               eq_prev[g] <= 1'b0;
            end else begin
               eq_prev[g] <= eq_now[g];
            end
         end
         property p_capture;
            @(posedge aclk) disable iff (!aresetn)
            mode[g] && capture_strobe[g] |=> gr_flag[g];
         endproperty
         a_capture: assert property (p_capture) // R05 R07 R15
            else $error("capture did not set its flag");
         property p_compare;
            @(posedge aclk) disable iff (!aresetn)
            !mode[g] && eq_now[g] && !$past(eq_now[g]) |=> gr_flag[g];
         endproperty
         a_compare: assert property (p_compare) // R06 R08 R15
            else $error("compare match did not set its flag");
      end
   endgenerate

   assign ch3_set  = {ch3_wrap_flag_set, gr_evt[3:0]}; // R01
   assign ch45_set = {ch4_wrap_flag_set, gr_evt[7:4], ch5_wrap_flag_set, gr_evt[9:8]}; // R02
   assign gr_flag  = {timer_ch4_ch5_status[1:0], timer_ch4_ch5_status[6:3], timer_ch3_status[3:0]};

   tsf_flag_bank #(
      .WIDTH(`TSF_CH3_W)
   ) u_ch3 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_evt (ch3_set),
      .rd_take (rd_go && (rd_word == `TSF_OFF_CH3)),
      .wr_take (wr_ch3 && wr_strb[0]),
      .wr_bits (wr_data[`TSF_CH3_W-1:0]),
      .flags   (timer_ch3_status)
   );

   tsf_flag_bank #(
      .WIDTH(`TSF_CH45_W)
   ) u_ch45 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_evt (ch45_set),
      .rd_take (rd_go && (rd_word == `TSF_OFF_CH45)),
      .wr_take (wr_ch45 && wr_strb[0]),
      .wr_bits (wr_data[`TSF_CH45_W-1:0]),
      .flags   (timer_ch4_ch5_status)
   );

   // Interrupt status: write one to clear, a new event wins
   assign irq_events = {ch3_set, ch45_set};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `TSF_IRQ_RST;
      end else if (wr_istat) begin
         irq_status <= (irq_status & ~(wr_data[`TSF_IRQ_W-1:0] & wr_mask[`TSF_IRQ_W-1:0]))
                       | irq_events;
      end else begin
         irq_status <= irq_status | irq_events;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= `TSF_IRQ_RST;
      end else if (wr_imask) begin
         irq_mask <= (irq_mask & ~wr_mask[`TSF_IRQ_W-1:0])
                     | (wr_data[`TSF_IRQ_W-1:0] & wr_mask[`TSF_IRQ_W-1:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   property p_ch3_wrap;
      @(posedge aclk) disable iff (!aresetn)
      ($past(ch3_counter) == `TSF_CNT_MAX) && (ch3_counter == `TSF_CNT_ZERO)
         |=> timer_ch3_status[`TSF_CH3_WRAP_BIT];
   endproperty
   a_ch3_wrap: assert property (p_ch3_wrap) // R03
      else $error("ch3 wrap flag not set");
   property p_ch4_wrap;
      @(posedge aclk) disable iff (!aresetn)
      ($past(ch4_counter) == `TSF_CNT_MAX) && (ch4_counter == `TSF_CNT_ZERO)
         |=> timer_ch4_ch5_status[`TSF_CH4_WRAP_BIT];
   endproperty
   a_ch4_wrap: assert property (p_ch4_wrap) // R04
      else $error("ch4 wrap flag not set");
   property p_ch5_wrap;
      @(posedge aclk) disable iff (!aresetn)
      ($past(ch5_counter) == `TSF_CNT_MAX) && (ch5_counter == `TSF_CNT_ZERO)
         |=> timer_ch4_ch5_status[`TSF_CH5_WRAP_BIT];
   endproperty
   a_ch5_wrap: assert property (p_ch5_wrap) // R14
      else $error("ch5 wrap flag not set");
   property p_ch3_upper_zero;
      @(posedge aclk) disable iff (!aresetn)
      rvalid && rd_is_ch3 |-> (rdata[31:`TSF_CH3_W] == '0);
   endproperty
   a_ch3_upper_zero: assert property (p_ch3_upper_zero) // R11
      else $error("ch3 register upper bits not zero");
   property p_write_answer;
      @(posedge aclk) disable iff (!aresetn)
      wr_go |=> bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write response missing");
   property p_rvalid_hold;
      @(posedge aclk) disable iff (!aresetn)
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold)
      else $error("read data dropped before rready");
   property p_irq_level;
      @(posedge aclk) disable iff (!aresetn)
      ##1 irq == |($past(irq_status) & $past(irq_mask));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq does not follow masked status");
endmodule

// [verif/timer_ch345_status_flags_bench.sv]
// Self-checking bench for the timer channel 3/4/5 status flag bank
`timescale 1ns/1ps
`include "tsf_consts.svh"
module timer_ch345_status_flags_bench;
   logic                      aclk;
   logic                      aresetn;
   logic [`TSF_ADDR_W-1:0]    awaddr;
   logic [`TSF_ADDR_W-1:0]    araddr;
   logic                      awvalid;
   logic                      wvalid;
   logic                      bready;
   logic                      arvalid;
   logic                      rready;
   logic [31:0]               wdata;
   logic [3:0]                wstrb;
   logic                      awready;
   logic                      wready;
   logic                      bvalid;
   logic                      arready;
   logic                      rvalid;
   logic                      irq;
   logic [1:0]                bresp;
   logic [1:0]                rresp;
   logic [31:0]               rdata;
   logic [`TSF_CNT_W-1:0]     cnt [3];
   logic [`TSF_CNT_W-1:0]     gr [10];
   logic [`TSF_N_GR-1:0]      capture_strobe;
   logic [`TSF_CH3_W-1:0]     timer_ch3_status;
   logic [`TSF_CH45_W-1:0]    timer_ch4_ch5_status;
   int                        n_mismatch = 0;
   int                        checks = 0;

   tsf_status_top DUT (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .ch3_counter(cnt[0]), .ch4_counter(cnt[1]), .ch5_counter(cnt[2]),
      .ch3_general_reg_a(gr[0]), .ch3_general_reg_b(gr[1]), .ch3_general_reg_c(gr[2]),
      .ch3_general_reg_d(gr[3]), .ch4_general_reg_a(gr[4]), .ch4_general_reg_b(gr[5]),
      .ch4_general_reg_c(gr[6]), .ch4_general_reg_d(gr[7]), .ch5_general_reg_a(gr[8]),
      .ch5_general_reg_b(gr[9]), .capture_strobe(capture_strobe),
      .timer_ch3_status(timer_ch3_status), .timer_ch4_ch5_status(timer_ch4_ch5_status),
      .irq(irq)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic give_verdict;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 50) begin
         n_mismatch++;
         give_verdict();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         tick(n);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", 32'(er), 32'(bresp));
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         tick(n);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      check("rdata", ed, rdata);
      check("rresp", 32'(er), 32'(rresp));
   endtask

   // Index 0..9 general registers as capture_strobe, 10..12 wrap of ch3, ch4, ch5
   function automatic logic [4:0] ra(input int k);
      return (k < 4 || k == 10) ? `TSF_OFF_CH3 : `TSF_OFF_CH45;
   endfunction

   function automatic logic [31:0] ex(input int k);
      int b;
      b = (k < 4) ? k : (k < 8) ? k - 1 : (k < 10) ? k - 8 : (k == 10) ? 4 : (k == 11) ? 7 : 2;
      return 32'h1 << b;
   endfunction

   task automatic pchk(input logic [4:0] a, input logic [31:0] e);
      repeat (2) @(posedge aclk);
      if (a == `TSF_OFF_CH3)
         check("ch3 port", e, 32'(timer_ch3_status));
      else
         check("ch45 port", e, 32'(timer_ch4_ch5_status));
   endtask

   task automatic ev(input int k, input bit cap);
      @(posedge aclk);
      if (k >= 10)
         cnt[k-10] <= 16'hFFFF;
      else if (cap)
         capture_strobe[k] <= 1'b1;
      else
         cnt[(k < 4) ? 0 : (k < 8) ? 1 : 2] <= gr[k];
      @(posedge aclk);
      capture_strobe <= '0;
      if (k >= 10) cnt[k-10] <= 16'h0000;
      @(posedge aclk);
      for (int i = 0; i < 3; i++) cnt[i] <= 16'h0001;
      repeat (3) @(posedge aclk);
   endtask

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      capture_strobe = '0;
      for (int i = 0; i < 3; i++) cnt[i] = 16'h0001;
      for (int i = 0; i < 10; i++) gr[i] = 16'h1000 + 16'(i);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
      rd(`TSF_OFF_CH45, 32'h0, `TSF_RESP_OKAY);
      check("irq", 32'h0, 32'(irq));
      rd(5'h14, 32'h0, `TSF_RESP_SLVERR);
      wr(5'h14, 32'hFF, `TSF_RESP_SLVERR);
      // Compare mode, then capture mode without the three wraps, each flag set, read, cleared
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 13 - 3 * m; k++) begin
            ev(k, m[0]);
            rd(ra(k), ex(k), `TSF_RESP_OKAY);
            pchk(ra(k), ex(k));
            wr(ra(k), 32'h0, `TSF_RESP_OKAY);
            rd(ra(k), 32'h0, `TSF_RESP_OKAY);
         end
         wr(`TSF_OFF_MODE, 32'h3FF, `TSF_RESP_OKAY);
      end
      // Zero write without a read, ones write, then a proper clear
      ev(10, 1'b0);
      wr(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
      pchk(`TSF_OFF_CH3, 32'h10);
      rd(`TSF_OFF_CH3, 32'h10, `TSF_RESP_OKAY);
      wr(`TSF_OFF_CH3, 32'hFF, `TSF_RESP_OKAY);
      pchk(`TSF_OFF_CH3, 32'h10);
      rd(`TSF_OFF_CH3, 32'h10, `TSF_RESP_OKAY);
      wr(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
      pchk(`TSF_OFF_CH3, 32'h0);
      // Interrupt raised only when unmasked, dropped by status clear
      ev(11, 1'b0);
      check("irq", 32'h0, 32'(irq));
      wr(`TSF_OFF_IRQ_MASK, 32'h80, `TSF_RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq", 32'h1, 32'(irq));
      wr(`TSF_OFF_IRQ_STAT, 32'h80, `TSF_RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq", 32'h0, 32'(irq));
      rd(`TSF_OFF_CH45, 32'h80, `TSF_RESP_OKAY);
      wr(`TSF_OFF_CH45, 32'h0, `TSF_RESP_OKAY);
      // Read and zero write back to back clear the flag
      ev(0, 1'b1);
      fork
         rd(`TSF_OFF_CH3, 32'h01, `TSF_RESP_OKAY);
         wr(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
      join
      pchk(`TSF_OFF_CH3, 32'h0);
      // Capture pulse on the clearing edge keeps the flag
      ev(0, 1'b1);
      rd(`TSF_OFF_CH3, 32'h01, `TSF_RESP_OKAY);
      fork
         wr(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
         begin
            repeat (2) @(posedge aclk);
            capture_strobe[0] <= 1'b1;
            @(posedge aclk);
            capture_strobe <= '0;
         end
      join
      pchk(`TSF_OFF_CH3, 32'h01);
      rd(`TSF_OFF_CH3, 32'h01, `TSF_RESP_OKAY);
      wr(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
      rd(`TSF_OFF_CH3, 32'h0, `TSF_RESP_OKAY);
      give_verdict();
   end
endmodule
